// ---- design/drz_pkg.sv ----
// package of the basic diagnostic record block: offsets, bit positions,
// codes and shared structs; no import, referenced as drz_pkg::name
// Overview of operation
// - every diagnostic handler call logs one history entry with cause and module address.
// - with diagnostics enabled the four basic bytes are ready when the handler is entered.
// - with the diagnostic interrupt disabled the last event is still held for reading.
// - an extended record beyond the four basic bytes can be read on request.
// - byte 0 bit 0 flags module failure from lost interrupt, missing supply or output fault.
// - byte 0 bit 1 flags an internal error from missing supply or output fault.
// - byte 0 bit 2 flags an external error and bits 7 to 5 read zero.
// - byte 0 bit 3 flags a present channel error.
// - byte 0 bit 4 flags a missing external supply.
// - byte 1 bits 3 to 0 hold class 1111b digital or 1000b function, bits 7 to 5 zero.
// - byte 1 bit 4 flags channel info for lost interrupt, missing supply or output fault.
// - byte 2 bit 4 flags missing internal supply and all other bits read zero.
// - incoming byte 3 bit 6 flags a lost process interrupt, other bits zero.
// - once errors clear an outgoing message is issued if release is on, byte 3 zero.
// - one basic layout serves alarm input, counter, frequency and pwm modes.
// - a repeat process interrupt for an event still being handled raises a diagnostic; one arriving while the diagnostic handler runs is dropped.
package drz_pkg;
  localparam logic [1:0] OFS_ERROR_SUMMARY  = 2'h0;
  localparam logic [1:0] OFS_MODULE_CLASS   = 2'h1;
  localparam logic [1:0] OFS_INT_SUPPLY     = 2'h2;
  localparam logic [1:0] OFS_LOST_INTERRUPT = 2'h3;
  localparam int B0_FAIL  = 0;
  localparam int B0_INT   = 1;
  localparam int B0_EXT   = 2;
  localparam int B0_CHAN  = 3;
  localparam int B0_XSUP  = 4;
  localparam int B1_CHINF = 4;
  localparam int B2_ISUP  = 4;
  localparam int B3_LOST  = 6;
  localparam logic [3:0] CLASS_DIGITAL  = 4'hF;
  localparam logic [3:0] CLASS_FUNCTION = 4'h8;
  localparam int EXT_BYTES   = 16;
  localparam int HIST_DEPTH  = 16;
  localparam int HIST_AW     = 4;
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_ALARM = 2'h0,
    MODE_COUNT = 2'h1,
    MODE_FREQ  = 2'h2,
    MODE_PWM   = 2'h3
  } drz_mode_t;

  typedef struct packed {
    logic       lost_irq;
    logic       sup_in_miss;
    logic       sup_out_miss;
    logic       out_short;
    logic       ext_err;
    logic       ext_sup_miss;
    logic [7:0] lost_chan;
  } drz_cause_t;

  typedef struct packed {
    logic       outgoing;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [15:0] mod_addr;
  } drz_entry_t;
endpackage

// ---- design/drz_hist_mem.sv ----
// diagnostic history buffer: ring of entries, registered read data
// assumes a single writer and a reader on the same clock
`timescale 1ns/1ps
module drz_hist_mem (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_wr,
  input  wire drz_pkg::drz_entry_t  i_wdata,
  input  wire logic [drz_pkg::HIST_AW-1:0] i_raddr,
  output drz_pkg::drz_entry_t       o_rdata,
  output logic [drz_pkg::HIST_AW-1:0] o_wptr
);
  drz_pkg::drz_entry_t mem [drz_pkg::HIST_DEPTH];
  typedef struct packed {
    logic [drz_pkg::HIST_AW-1:0] wptr;
    drz_pkg::drz_entry_t         rdata;
  } drz_hm_state_t;
  drz_hm_state_t st_reg, st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.rdata = mem[i_raddr];
    if (i_wr) begin
      st_next.wptr = st_reg.wptr + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_wr) begin
      mem[st_reg.wptr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_wptr  = st_reg.wptr;
endmodule // drz_hist_mem

// ---- design/drz_sync.sv ----
// two-flop synchroniser for one pin-level input
// assumes input is asynchronous to i_clk
`timescale 1ns/1ps
module drz_sync (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_d,
  output logic      o_q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } drz_sy_state_t;
  drz_sy_state_t st_reg, st_next;

  always_comb begin
    st_next.s1 = i_d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_q = st_reg.s2;
endmodule // drz_sync

// ---- design/diag_record_set_zero.sv ----
// basic diagnostic record generator with history log and record reads
// assumes cause inputs are same-clock levels except the two supply pins
`timescale 1ns/1ps
module diag_record_set_zero (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_diag_enable,
  input  wire logic                 i_diag_irq_release,
  input  wire logic [1:0]           i_mode,
  input  wire logic [15:0]          i_mod_addr,
  input  wire logic                 i_proc_irq,
  input  wire logic [7:0]           i_proc_event,
  input  wire logic                 i_proc_irq_busy,
  input  wire logic                 i_sup_in_ok_pin,
  input  wire logic                 i_sup_out_ok_pin,
  input  wire logic                 i_out_short,
  input  wire logic                 i_ext_err,
  input  wire logic                 i_ext_sup_miss,
  input  wire logic                 i_handler_done,
  input  wire logic                 i_rd_req,
  input  wire logic                 i_rd_ext,
  input  wire logic [3:0]           i_rd_addr,
  input  wire logic [3:0]           i_hist_addr,
  output logic                      o_diag_handler_call,
  output logic                      o_outgoing,
  output logic [31:0]               o_local_dword,
  output logic                      o_rd_valid,
  output logic [7:0]                o_rd_data,
  output drz_pkg::drz_entry_t       o_hist_data,
  output logic [3:0]                o_hist_wptr
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_IN   = 3'b010,
    ST_OUT  = 3'b100
  } drz_st_t;

  typedef struct packed {
    drz_st_t          fsm;
    logic [7:0]       b0;
    logic [7:0]       b1;
    logic [7:0]       b2;
    logic [7:0]       b3;
    logic [7:0]       held_event;
    logic [7:0]       lost_chan;
    logic             active;
    logic             call;
    logic             outg;
    logic             rd_valid;
    logic [7:0]       rd_data;
  } drz_state_t;

  drz_state_t st_reg, st_next;
  logic       sup_in_miss, sup_out_miss;
  logic       lost_now, fault_any, sup_miss;
  logic       log_wr;
  drz_pkg::drz_entry_t log_entry;
  logic [7:0] nb0, nb1, nb2, nb3;

  // synced as miss: the cleared sync stage then reads supply ok,
  // so leaving reset raises no false call
  drz_sync u_sync_in (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_d       (!i_sup_in_ok_pin),
    .o_q       (sup_in_miss)
  );
  drz_sync u_sync_out (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_d       (!i_sup_out_ok_pin),
    .o_q       (sup_out_miss)
  );

  // repeat for the event already in service is the lost interrupt
  assign lost_now = i_proc_irq && i_proc_irq_busy
                    && ((i_proc_event & st_reg.held_event) != 8'h00);
  assign sup_miss  = sup_in_miss || sup_out_miss;
  assign fault_any = lost_now || sup_miss || i_out_short;

  // same layout for every mode; only the class nibble follows the mode
  always_comb begin
    nb0 = 8'h00;
    nb0[drz_pkg::B0_FAIL] = fault_any;
    nb0[drz_pkg::B0_INT]  = sup_miss || i_out_short;
    nb0[drz_pkg::B0_EXT]  = i_ext_err;
    nb0[drz_pkg::B0_CHAN] = fault_any;
    nb0[drz_pkg::B0_XSUP] = i_ext_sup_miss;
    nb1 = 8'h00;
    nb1[3:0] = (i_mode == drz_pkg::MODE_ALARM)
               ? drz_pkg::CLASS_DIGITAL
               : drz_pkg::CLASS_FUNCTION;
    nb1[drz_pkg::B1_CHINF] = fault_any;
    nb2 = 8'h00;
    nb2[drz_pkg::B2_ISUP] = sup_miss;
    nb3 = 8'h00;
    nb3[drz_pkg::B3_LOST] = lost_now;
  end

  always_comb begin
    st_next          = st_reg;
    st_next.call     = 1'b0;
    st_next.rd_valid = 1'b0;
    if (i_proc_irq && !i_proc_irq_busy) begin
      st_next.held_event = i_proc_event;
    end
    case (st_reg.fsm)
      ST_IDLE: begin
        if (fault_any || i_ext_err || i_ext_sup_miss) begin
          // record always latched, so a disabled interrupt still reads back
          st_next.b0 = nb0;
          st_next.b1 = nb1;
          st_next.b2 = nb2;
          st_next.b3 = nb3;
          st_next.lost_chan = lost_now ? i_proc_event : 8'h00;
          st_next.active = 1'b1;
          if (i_diag_enable) begin
            st_next.call = 1'b1;
            st_next.outg = 1'b0;
            st_next.fsm  = ST_IN;
          end
        end else if (st_reg.active) begin
          st_next.active = 1'b0;
          st_next.b3     = 8'h00;
          if (i_diag_enable && i_diag_irq_release) begin
            st_next.call = 1'b1;
            st_next.outg = 1'b1;
            st_next.fsm  = ST_OUT;
          end
        end
      end
      ST_IN: begin
        if (i_handler_done) begin
          st_next.fsm = ST_IDLE;
        end
      end
      ST_OUT: begin
        if (i_handler_done) begin
          st_next.fsm = ST_IDLE;
        end
      end
      default: st_next.fsm = ST_IDLE;
    endcase
    // extended record: bytes 0-3 basic, 4 lost channels, rest zero
    if (i_rd_req) begin
      st_next.rd_valid = 1'b1;
      if (!i_rd_ext && i_rd_addr[3:2] != 2'h0) begin
        st_next.rd_data = 8'h00;
      end else if (i_rd_addr[1:0] == drz_pkg::OFS_ERROR_SUMMARY
                   && i_rd_addr[3:2] == 2'h0) begin
        st_next.rd_data = st_reg.b0;
      end else if (i_rd_addr[1:0] == drz_pkg::OFS_MODULE_CLASS
                   && i_rd_addr[3:2] == 2'h0) begin
        st_next.rd_data = st_reg.b1;
      end else if (i_rd_addr[1:0] == drz_pkg::OFS_INT_SUPPLY
                   && i_rd_addr[3:2] == 2'h0) begin
        st_next.rd_data = st_reg.b2;
      end else if (i_rd_addr[1:0] == drz_pkg::OFS_LOST_INTERRUPT
                   && i_rd_addr[3:2] == 2'h0) begin
        st_next.rd_data = st_reg.b3;
      end else if (i_rd_addr == 4'h4) begin
        st_next.rd_data = st_reg.lost_chan;
      end else begin
        st_next.rd_data = 8'h00;
      end
    end
  end

  // log uses next record so cause matches the call being raised
  assign log_wr = st_next.call;
  always_comb begin
    log_entry.outgoing = st_next.outg;
    log_entry.b0       = st_next.b0;
    log_entry.b1       = st_next.b1;
    log_entry.b2       = st_next.b2;
    log_entry.b3       = st_next.b3;
    log_entry.mod_addr = i_mod_addr;
  end

  drz_hist_mem u_hist (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_wr      (log_wr),
    .i_wdata   (log_entry),
    .i_raddr   (i_hist_addr),
    .o_rdata   (o_hist_data),
    .o_wptr    (o_hist_wptr)
  );

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg     <= '0;
      st_reg.fsm <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_diag_handler_call = st_reg.call;
  assign o_outgoing          = st_reg.outg;
  assign o_local_dword = {st_reg.b3, st_reg.b2, st_reg.b1, st_reg.b0};
  assign o_rd_valid          = st_reg.rd_valid;
  assign o_rd_data           = st_reg.rd_data;
endmodule // diag_record_set_zero

// ---- sim/drz_props.sv ----
// checker of the diagnostic record block, sees the top-level ports only
// assumes i_mode is held steady around each handler call
`timescale 1ns/1ps
module drz_props (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_diag_enable,
  input wire logic        i_diag_irq_release,
  input wire logic [1:0]  i_mode,
  input wire logic        i_rd_req,
  input wire logic        o_diag_handler_call,
  input wire logic        o_outgoing,
  input wire logic [31:0] o_local_dword,
  input wire logic        o_rd_valid,
  input wire logic [3:0]  o_hist_wptr
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_b0_top_zero: assert property (o_local_dword[7:5] == 3'h0)
    else $error("byte 0 top bits set");
  a_class_code: assert property (o_diag_handler_call |->
    (o_local_dword[15:8] & 8'hEF) == ($past(i_mode)==2'h0 ? 8'h0F : 8'h08))
    else $error("module class wrong");
  a_b2_spare_zero: assert property ((o_local_dword[23:16] & 8'hEF) == 8'h00)
    else $error("byte 2 spare bits set");
  a_b3_lost_only: assert property ((o_local_dword[31:24] & 8'hBF) == 8'h00)
    else $error("byte 3 spare bits set");
  a_out_b3_clear: assert property (o_diag_handler_call && o_outgoing |->
    o_local_dword[31:24] == 8'h00 && $past(i_diag_irq_release))
    else $error("outgoing record wrong");
  a_int_is_fail: assert property (o_local_dword[1] |->
    o_local_dword[0] && o_local_dword[12])
    else $error("internal error without failure");
  a_chan_is_fail: assert property (o_local_dword[3] == o_local_dword[0])
    else $error("channel bit differs");
  a_log_per_call: assert property (o_diag_handler_call |->
    o_hist_wptr == $past(o_hist_wptr) + 4'h1)
    else $error("call without history entry");
  a_quiet_off: assert property (!i_diag_enable |=> !o_diag_handler_call)
    else $error("call while disabled");
  a_read_answer: assert property (i_rd_req |=> o_rd_valid)
    else $error("read not answered");
endmodule // drz_props

bind diag_record_set_zero drz_props u_drz_props (.i_clk, .i_reset_n,
  .i_diag_enable, .i_diag_irq_release, .i_mode, .i_rd_req,
  .o_diag_handler_call, .o_outgoing, .o_local_dword, .o_rd_valid,
  .o_hist_wptr);

// ---- sim/drz_cpu_model.sv ----
// model of the cpu handler that services diagnostic handler calls
// assumes calls last one cycle; drives just after the rising edge
`timescale 1ns/1ps
module drz_cpu_model (
  input  wire logic i_clk,
  input  wire logic i_call,
  input  wire logic i_slow,
  output logic      o_done
);
  initial o_done = 1'b0;
  always @(posedge i_clk) begin
    if (i_call) begin
      // a slow handler holds off the next call of the device
      repeat (i_slow ? 20 : 2) @(posedge i_clk);
      #1 o_done = 1'b1;
      @(posedge i_clk);
      #1 o_done = 1'b0;
    end
  end
endmodule // drz_cpu_model

// ---- sim/diag_record_set_zero_bench.sv ----
// testbench of the diagnostic record block with a cpu handler model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module diag_record_set_zero_bench;
  logic        i_clk, i_reset_n, i_diag_enable, i_diag_irq_release, slow;
  logic        i_proc_irq, i_proc_irq_busy, i_sup_in_ok_pin, i_sup_out_ok_pin;
  logic        i_out_short, i_ext_err, i_ext_sup_miss, i_handler_done;
  logic        i_rd_req, i_rd_ext, o_diag_handler_call, o_outgoing, o_rd_valid;
  logic [1:0]  i_mode;
  logic [15:0] i_mod_addr;
  logic [7:0]  i_proc_event, o_rd_data;
  logic [3:0]  i_rd_addr, i_hist_addr, o_hist_wptr;
  logic [31:0] o_local_dword;
  drz_pkg::drz_entry_t o_hist_data;
  int          bad_count, samples_checked;

  diag_record_set_zero u_diag_record_set_zero (.*);
  drz_cpu_model u_drz_cpu_model (.i_clk, .i_call(o_diag_handler_call),
    .i_slow(slow), .o_done(i_handler_done));

  always #20 i_clk = ~i_clk;

  task automatic conclude();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wcall();
    int k = 0;
    do begin
      tick(1);
      k++;
    end while (o_diag_handler_call !== 1'b1 && k < 80);
    if (k == 80) begin
      chk("handler call", 1, 0);
      conclude();
    end
  endtask

  task automatic rd(logic x, logic [3:0] a, logic [7:0] m, logic [7:0] e);
    {i_rd_req, i_rd_ext, i_rd_addr} = {1'b1, x, a};
    tick(1);
    chk("read valid", 1, o_rd_valid);
    chk("read data", e, o_rd_data & m);
    // one idle edge so back-to-back reads never rewrite the strobe at once
    i_rd_req = 1'b0;
    tick(1);
  endtask

  // incoming record under mask, then cleared causes give the outgoing one
  task automatic pair(logic [31:0] m, logic [31:0] e);
    wcall();
    chk("incoming", 0, o_outgoing);
    chk("record", e, o_local_dword & m);
    {i_out_short, i_ext_err, i_ext_sup_miss} = '0;
    {i_sup_in_ok_pin, i_sup_out_ok_pin} = '1;
    wcall();
    chk("outgoing", 1, o_outgoing);
    chk("outgoing byte 3", 0, o_local_dword[31:24]);
  endtask

  task automatic t_short();
    i_out_short = 1'b1;
    pair(32'hFFFFFFFF, 32'h00001F0B);
    tick(2);
    chk("hist b0", 8'h0B, o_hist_data.b0);
    chk("hist addr", 16'hA5C3, o_hist_data.mod_addr);
    i_hist_addr = 4'h1;
    tick(2);
    chk("hist out", 1, o_hist_data.outgoing);
    chk("wptr", 2, o_hist_wptr);
  endtask

  task automatic t_lost();
    // a repeat pulse is refused while a handler runs, so let it finish
    slow = 1'b0;
    tick(25);
    {i_mode, i_proc_event, i_proc_irq} = {2'h1, 8'h01, 1'b1};
    tick(1);
    {i_proc_irq, i_proc_irq_busy} = 2'b01;
    tick(1);
    i_proc_irq = 1'b1;
    wcall();
    i_proc_irq = 1'b0;
    chk("lost record", 32'h40001809, o_local_dword);
    rd(0, 4'h3, 8'hFF, 8'h40);
    rd(1, 4'h4, 8'hFF, 8'h01);
    rd(0, 4'h4, 8'hFF, 8'h00);
    i_proc_irq_busy = 1'b0;
  endtask

  initial begin
    {i_clk, i_reset_n, i_proc_irq, i_proc_irq_busy, i_out_short, i_ext_err,
     i_ext_sup_miss, i_rd_req, i_rd_ext, slow} = '0;
    {i_diag_enable, i_diag_irq_release, i_sup_in_ok_pin,
     i_sup_out_ok_pin} = '1;
    {i_mode, i_mod_addr, i_proc_event} = {2'h0, 16'hA5C3, 8'h00};
    {i_rd_addr, i_hist_addr, bad_count, samples_checked} = '0;
    tick(4);
    chk("reset dword", 0, o_local_dword);
    i_reset_n = 1'b1;
    tick(2);
    t_short();
    {i_mode, i_ext_err} = {2'h1, 1'b1};
    pair(32'hFFFFFFFF, 32'h00000804);
    {i_mode, i_ext_sup_miss} = {2'h2, 1'b1};
    pair(32'h000000F1, 32'h00000010);
    {i_mode, slow, i_sup_in_ok_pin, i_sup_out_ok_pin} = {2'h3, 3'b100};
    pair(32'hFFFFFFFF, 32'h0010180B);
    t_lost();
    tick(30);
    {i_diag_enable, i_ext_err} = 2'b01;
    tick(10);
    // five incoming and outgoing pairs logged, none while disabled
    chk("wptr off", 4'hA, o_hist_wptr);
    rd(0, 4'h0, 8'h04, 8'h04);
    conclude();
  end
endmodule // diag_record_set_zero_bench
